// file: inc/dgpio_map.vh
// Register map, field positions and reset values of the two-port GPIO block.
// What this block does
// (R1) First port: six pins, direction one is input.
// (R2) Data read returns pins; write loads latch.
// (R3) Set and clear writes sample pins, modify, store latch.
// (R4) First-port bit 4 is timer clock, open-drain.
// (R5) Analog field selects analog use of pins.
// (R6) Reset leaves analog pins analog, reading zero.
// (R7) Direction bits still govern pins in analog use.
// (R8) Unimplemented bits read as zero.
// (R9) Second port: eight pins, direction one is input.
// (R10) Active-low option bit 7 enables all pull-ups.
// (R11) Pull-up off on any output pin.
// (R12) Reset leaves all pull-ups disabled.
// (R13) Only upper four input pins watched for change.
// (R14) Mismatch against value taken at last port access sets flag bit 0.
// (R15) Port-change event wakes device from sleep.
// (R16) Flag keeps setting while mismatch persists.
// (R17) Software avoids polling port during change use.
// (R18) Second-port bit 0 is edge-selected external interrupt.
// (R19) Bits 3, 6, 7 serve low-voltage programming.
// (R20) Enabled low-voltage programming takes over its shared pins.
// (R21) All pin inputs synchronised before use.
`ifndef DGPIO_MAP_VH
`define DGPIO_MAP_VH
// ****************************************************************
// Register indices; the byte address is four times the index.
// ****************************************************************
`define DGPIO_IDX_PA_DATA  8'h05
`define DGPIO_IDX_PA_DIR   8'h85
`define DGPIO_IDX_ANCFG    8'h9F
`define DGPIO_IDX_PB_DATA  8'h06
`define DGPIO_IDX_PB_DIR   8'h86
`define DGPIO_IDX_OPTION   8'h81
`define DGPIO_IDX_INTCTL   8'h0B
`define DGPIO_IDX_PA_SET   8'hA0
`define DGPIO_IDX_PA_CLR   8'hA1
`define DGPIO_IDX_PB_SET   8'hA2
`define DGPIO_IDX_PB_CLR   8'hA3
`define DGPIO_IDX_LVPCFG   8'hA4
// ****************************************************************
// Reset values.
// ****************************************************************
`define DGPIO_RST_PA_DIR   6'h3F
`define DGPIO_RST_PB_DIR   8'hFF
`define DGPIO_RST_ANCFG    8'h00
`define DGPIO_RST_OPTION   8'hFF
`define DGPIO_RST_INTCTL   8'h00
`define DGPIO_RST_LATCH6   6'h00
`define DGPIO_RST_LATCH8   8'h00
// ****************************************************************
// Field positions.
// ****************************************************************
`define DGPIO_OPT_PULLUP_N  7
`define DGPIO_OPT_EDGE_SEL  6
`define DGPIO_INT_CHG_FLAG  0
`define DGPIO_INT_EXT_FLAG  1
`define DGPIO_INT_CHG_EN    3
`define DGPIO_INT_EXT_EN    4
`define DGPIO_AN_FIELD      3:0
`define DGPIO_AN_JUSTIFY_MASK 8'h8F
`define DGPIO_AN_DIGITAL_A  4'h6
`define DGPIO_AN_DIGITAL_B  4'h7
`define DGPIO_PA_TIMER_BIT  4
`define DGPIO_PA_ANALOG_MASK 6'h2F
`define DGPIO_PB_EXT_BIT    0
`define DGPIO_PB_PGM_BIT    3
`define DGPIO_PB_PGC_BIT    6
`define DGPIO_PB_PGD_BIT    7
`define DGPIO_PB_CHG_MASK   8'hF0
`define DGPIO_PB_LVP_MASK   8'hC8
`define DGPIO_LVP_EN_BIT    0
// ****************************************************************
// Timing counts.
// ****************************************************************
`define DGPIO_PRIME_CYCLES  3'h5
`define DGPIO_PRIME_STEP    3'h1
`define DGPIO_PRIME_RST     3'h0
`endif

// file: logic/dgpio_port.v
// Two-port GPIO block with change detection, external interrupt edge and Wishbone register access.
`timescale 1ns/10ps
`include "dgpio_map.vh"
module dgpio_port (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        cyc_i,
	input  wire        stb_i,
	input  wire        we_i,
	input  wire [9:0]  adr_i,
	input  wire [3:0]  sel_i,
	input  wire [31:0] dat_i,
	output reg  [31:0] dat_o,
	output reg         ack_o,
	input  wire        sleep_i,
	input  wire [5:0]  pa_in_i,
	output reg  [5:0]  pa_out_o,
	output reg  [5:0]  pa_oe_o,
	output reg  [5:0]  pa_analog_o,
	input  wire [7:0]  pb_in_i,
	output reg  [7:0]  pb_out_o,
	output reg  [7:0]  pb_oe_o,
	output reg  [7:0]  pb_pullup_o,
	output reg         timer_clock_o,
	output reg         wake_o,
	output reg         prog_mode_o,
	output reg         prog_clock_o,
	output reg         prog_data_o
);
	// ****************************************************************
	// Storage.
	// ****************************************************************
	reg  [5:0]  pa_latch_reg;
	reg  [5:0]  pa_dir_reg;
	reg  [7:0]  ancfg_reg;
	reg  [7:0]  pb_latch_reg;
	reg  [7:0]  pb_dir_reg;
	reg  [7:0]  option_reg;
	reg  [7:0]  intctl_reg;
	reg  [7:0]  lvpcfg_reg;
	reg  [7:0]  pb_old_reg;
	reg         ext_prev_reg;
	reg  [2:0]  prime_reg;
	wire        prime_ready;
	reg  [13:0] sync1_reg;
	reg  [13:0] sync2_reg;
	reg  [13:0] sync3_reg;
	reg  [13:0] pin_reg;
	reg  [31:0] rdat_next;
	wire [7:0]  idx;
	wire        req;
	wire        wr;
	wire        rd;
	wire [5:0]  pa_pins;
	wire [7:0]  pb_pins;
	wire [5:0]  pa_analog;
	wire [5:0]  pa_read;
	wire        lvp_en;
	wire [7:0]  pb_drive;
	wire [7:0]  chg_mismatch;
	wire        chg_event;
	wire        ext_edge;
	wire        pb_access;
	wire [7:0]  wbyte;
	wire [7:0]  intctl_next;

	// Decodes one register index against the bus address.
	function hit;
		input [7:0] a;
		input [7:0] b;
		begin
			hit = (a == b);
		end
	endfunction

	// ****************************************************************
	// Bus decode.
	// ****************************************************************
	assign idx   = adr_i[9:2];
	assign req   = cyc_i & stb_i & ~ack_o;
	assign wr    = req & we_i & sel_i[0];
	assign rd    = req & ~we_i;
	assign wbyte = dat_i[7:0];

	// ****************************************************************
	// Input synchronisers, three stages, change taken when stages agree.
	// ****************************************************************
	genvar g;
	generate
		for (g = 0; g < 14; g = g + 1) begin : g_sync
			always @(posedge clk_i) begin
				if (rst_i) begin
					sync1_reg[g] <= 1'b0;
					sync2_reg[g] <= 1'b0;
					sync3_reg[g] <= 1'b0;
					pin_reg[g]   <= 1'b0;
				end else begin
					sync1_reg[g] <= (g < 6) ? pa_in_i[g] : pb_in_i[g - 6]; // R21
					sync2_reg[g] <= sync1_reg[g];
					sync3_reg[g] <= sync2_reg[g];
					if (sync2_reg[g] == sync3_reg[g]) begin
						pin_reg[g] <= sync3_reg[g]; // R21
					end
				end
			end
		end
	endgenerate

	assign pa_pins = pin_reg[5:0];
	assign pb_pins = pin_reg[13:6];

	// ****************************************************************
	// Analog selection and pin functions.
	// ****************************************************************
	assign pa_analog = ((ancfg_reg[`DGPIO_AN_FIELD] == `DGPIO_AN_DIGITAL_A) |
		(ancfg_reg[`DGPIO_AN_FIELD] == `DGPIO_AN_DIGITAL_B)) ? 6'h00 : `DGPIO_PA_ANALOG_MASK; // R5
	assign pa_read   = pa_pins & ~pa_analog; // R6
	assign lvp_en    = lvpcfg_reg[`DGPIO_LVP_EN_BIT];
	assign pb_drive  = ~pb_dir_reg & ~(lvp_en ? `DGPIO_PB_LVP_MASK : 8'h00); // R20

	// ****************************************************************
	// Change detection and external edge.
	// ****************************************************************
	assign chg_mismatch = (pb_pins ^ pb_old_reg) & pb_dir_reg & `DGPIO_PB_CHG_MASK; // R13
	// Edges and mismatches are ignored until the synchronisers hold real pin levels.
	assign prime_ready  = (prime_reg == `DGPIO_PRIME_CYCLES);
	assign chg_event    = prime_ready & (|chg_mismatch); // R14
	assign ext_edge     = prime_ready & (option_reg[`DGPIO_OPT_EDGE_SEL] ?
		(pb_pins[`DGPIO_PB_EXT_BIT] & ~ext_prev_reg) :
		(~pb_pins[`DGPIO_PB_EXT_BIT] & ext_prev_reg)); // R18
	assign pb_access    = req & (hit(idx, `DGPIO_IDX_PB_DATA) | hit(idx, `DGPIO_IDX_PB_SET) |
		hit(idx, `DGPIO_IDX_PB_CLR));

	// Flag bits: hardware set wins over a software clear in the same cycle.
	assign intctl_next = {
		(wr & hit(idx, `DGPIO_IDX_INTCTL)) ? wbyte[7:2] : intctl_reg[7:2],
		ext_edge  | ((wr & hit(idx, `DGPIO_IDX_INTCTL)) ? wbyte[1] : intctl_reg[1]), // R18
		chg_event | ((wr & hit(idx, `DGPIO_IDX_INTCTL)) ? wbyte[0] : intctl_reg[0])  // R16
	};

	// ****************************************************************
	// Register writes.
	// ****************************************************************
	always @(posedge clk_i) begin
		if (rst_i) begin
			pa_latch_reg <= `DGPIO_RST_LATCH6;
			pa_dir_reg   <= `DGPIO_RST_PA_DIR;
			ancfg_reg    <= `DGPIO_RST_ANCFG;
			pb_latch_reg <= `DGPIO_RST_LATCH8;
			pb_dir_reg   <= `DGPIO_RST_PB_DIR;
			option_reg   <= `DGPIO_RST_OPTION; // R12
			intctl_reg   <= `DGPIO_RST_INTCTL;
			lvpcfg_reg   <= `DGPIO_RST_INTCTL;
			pb_old_reg   <= `DGPIO_RST_LATCH8;
			ext_prev_reg <= 1'b0;
			prime_reg    <= `DGPIO_PRIME_RST;
		end else begin
			ext_prev_reg <= pb_pins[`DGPIO_PB_EXT_BIT];
			intctl_reg   <= intctl_next; // R14
			if (!prime_ready) begin
				prime_reg <= prime_reg + `DGPIO_PRIME_STEP; // R21
			end
			if (pb_access | ~prime_ready) begin
				pb_old_reg <= pb_pins; // R16
			end
			if (wr) begin
				case (idx)
					`DGPIO_IDX_PA_DATA: pa_latch_reg <= wbyte[5:0]; // R2
					`DGPIO_IDX_PA_SET:  pa_latch_reg <= pa_read | wbyte[5:0]; // R3
					`DGPIO_IDX_PA_CLR:  pa_latch_reg <= pa_read & ~wbyte[5:0]; // R3
					`DGPIO_IDX_PA_DIR:  pa_dir_reg <= wbyte[5:0]; // R1
					`DGPIO_IDX_ANCFG:   ancfg_reg <= wbyte & `DGPIO_AN_JUSTIFY_MASK; // R5
					`DGPIO_IDX_PB_DATA: pb_latch_reg <= wbyte; // R2
					`DGPIO_IDX_PB_SET:  pb_latch_reg <= pb_pins | wbyte; // R3
					`DGPIO_IDX_PB_CLR:  pb_latch_reg <= pb_pins & ~wbyte; // R3
					`DGPIO_IDX_PB_DIR:  pb_dir_reg <= wbyte; // R9
					`DGPIO_IDX_OPTION:  option_reg <= wbyte;
					`DGPIO_IDX_LVPCFG:  lvpcfg_reg <= {7'h00, wbyte[0]};
					default: begin
					end
				endcase
			end
		end
	end

	// ****************************************************************
	// Register reads; unmapped indices return zero.
	// ****************************************************************
	always @* begin
		rdat_next = 32'h00000000;
		case (idx)
			`DGPIO_IDX_PA_DATA: rdat_next[5:0] = pa_read; // R8
			`DGPIO_IDX_PA_DIR:  rdat_next[5:0] = pa_dir_reg; // R8
			`DGPIO_IDX_ANCFG:   rdat_next[7:0] = ancfg_reg;
			`DGPIO_IDX_PB_DATA: rdat_next[7:0] = pb_pins; // R2
			`DGPIO_IDX_PB_DIR:  rdat_next[7:0] = pb_dir_reg;
			`DGPIO_IDX_OPTION:  rdat_next[7:0] = option_reg;
			`DGPIO_IDX_INTCTL:  rdat_next[7:0] = intctl_reg;
			`DGPIO_IDX_LVPCFG:  rdat_next[7:0] = lvpcfg_reg;
			default:            rdat_next = 32'h00000000;
		endcase
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
		end else begin
			ack_o <= req;
			dat_o <= rd ? rdat_next : 32'h00000000;
		end
	end

	// ****************************************************************
	// Pin drivers and side outputs.
	// ****************************************************************
	always @(posedge clk_i) begin
		if (rst_i) begin
			pa_out_o      <= 6'h00;
			pa_oe_o       <= 6'h00;
			pa_analog_o   <= `DGPIO_PA_ANALOG_MASK;
			pb_out_o      <= 8'h00;
			pb_oe_o       <= 8'h00;
			pb_pullup_o   <= 8'h00;
			timer_clock_o <= 1'b0;
			wake_o        <= 1'b0;
			prog_mode_o   <= 1'b0;
			prog_clock_o  <= 1'b0;
			prog_data_o   <= 1'b0;
		end else begin
			pa_out_o    <= pa_latch_reg & ~(6'h01 << `DGPIO_PA_TIMER_BIT); // R4
			pa_oe_o     <= ~pa_dir_reg & ~(pa_latch_reg & (6'h01 << `DGPIO_PA_TIMER_BIT)); // R1 R4 R7
			pa_analog_o <= pa_analog; // R5
			pb_out_o    <= pb_latch_reg;
			pb_oe_o     <= pb_drive; // R9
			pb_pullup_o <= ~{8{option_reg[`DGPIO_OPT_PULLUP_N]}} & pb_dir_reg; // R10 R11
			timer_clock_o <= pa_pins[`DGPIO_PA_TIMER_BIT]; // R4
			wake_o      <= sleep_i & intctl_reg[`DGPIO_INT_CHG_EN] & intctl_reg[`DGPIO_INT_CHG_FLAG]; // R15
			prog_mode_o  <= lvp_en & pb_pins[`DGPIO_PB_PGM_BIT]; // R19
			prog_clock_o <= lvp_en & pb_pins[`DGPIO_PB_PGC_BIT]; // R19
			prog_data_o  <= lvp_en & pb_pins[`DGPIO_PB_PGD_BIT]; // R19
		end
	end
endmodule // dgpio_port

// file: tb/dgpio_chk.sv
// Checker of the port relations of the two-port GPIO block.
`timescale 1ns/10ps
module dgpio_chk (
	input wire        clk_i,
	input wire        rst_i,
	input wire        cyc_i,
	input wire        stb_i,
	input wire        sleep_i,
	input wire [31:0] dat_o,
	input wire        ack_o,
	input wire [5:0]  pa_out_o,
	input wire [5:0]  pa_oe_o,
	input wire [5:0]  pa_analog_o,
	input wire [7:0]  pb_oe_o,
	input wire [7:0]  pb_pullup_o,
	input wire        wake_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack held too long");
	a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack missing");
	a_idle_dat_zero: assert property (!ack_o |-> dat_o == 32'h0) else $error("data without ack");
	a_upper_bits_zero: assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("upper bits set");
	a_drain_open: assert property (pa_out_o[4] == 1'b0) else $error("bit 4 drives high");
	a_pullup_output: assert property ((pb_oe_o & pb_pullup_o) == 8'h00) else $error("pull-up on output");
	a_wake_sleep: assert property (wake_o |-> $past(sleep_i)) else $error("wake outside sleep");
	a_reset_state: assert property ($past(rst_i) |-> pb_pullup_o == 8'h00 && pa_analog_o == 6'h2F
		&& pa_oe_o == 6'h00) else $error("bad state after reset");
endmodule // dgpio_chk
bind dgpio_port dgpio_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .sleep_i(sleep_i),
	.dat_o(dat_o), .ack_o(ack_o), .pa_out_o(pa_out_o), .pa_oe_o(pa_oe_o), .pa_analog_o(pa_analog_o),
	.pb_oe_o(pb_oe_o), .pb_pullup_o(pb_pullup_o), .wake_o(wake_o));

// file: tb/dgpio_pins.sv
// Board model that resolves the port pin levels.
`timescale 1ns/10ps
module dgpio_pins (
	input  wire         clk_i,
	input  wire  [5:0]  pa_out_i,
	input  wire  [5:0]  pa_oe_i,
	input  wire  [7:0]  pb_out_i,
	input  wire  [7:0]  pb_oe_i,
	input  wire  [7:0]  pb_pullup_i,
	input  wire  [13:0] ext_i,
	input  wire  [13:0] en_i,
	output logic [5:0]  pa_pin_o,
	output logic [7:0]  pb_pin_o
);
	logic [13:0] flt_reg = 14'h2AAA;
	always @(posedge clk_i) begin
		flt_reg <= ~flt_reg;
	end
	// A pin nobody holds toggles every cycle.
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			pa_pin_o[i] = pa_oe_i[i] ? pa_out_i[i] : (en_i[i] ? ext_i[i] : flt_reg[i]);
		end
		for (int i = 0; i < 8; i++) begin
			pb_pin_o[i] = pb_oe_i[i] ? pb_out_i[i] : (en_i[i+6] ? ext_i[i+6] : pb_pullup_i[i] | flt_reg[i+6]);
		end
	end
endmodule // dgpio_pins

// file: tb/dgpio_port_tb.sv
// Self-checking bench of the two-port GPIO block.
`timescale 1ns/10ps
`include "dgpio_map.vh"
`define chk_eq(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module dgpio_port_tb;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic        sleep = 1'b0;
	logic [9:0]  adr = 10'h000;
	logic [31:0] dat_w = 32'h0;
	logic [31:0] dat_r;
	logic [31:0] v;
	logic        ack;
	logic        tclk;
	logic        wake;
	logic [5:0]  pa_in, pa_out, pa_oe, pa_an;
	logic [7:0]  pb_in, pb_out, pb_oe, pb_pu, q;
	logic [13:0] ext = 14'h3FFF;
	logic [13:0] en = 14'h3FFF;
	int          num_errors = 0;
	int          total_checks = 0;
	int          cycles = 0;
	int          e;
	logic [7:0]  idx [6] = '{`DGPIO_IDX_PA_DIR, `DGPIO_IDX_PB_DIR, `DGPIO_IDX_ANCFG, `DGPIO_IDX_OPTION,
		`DGPIO_IDX_INTCTL, 8'h40};
	logic [7:0]  rst [6] = '{8'h3F, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00};
	dgpio_port DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF),
		.dat_i(dat_w), .dat_o(dat_r), .ack_o(ack), .sleep_i(sleep), .pa_in_i(pa_in), .pa_out_o(pa_out),
		.pa_oe_o(pa_oe), .pa_analog_o(pa_an), .pb_in_i(pb_in), .pb_out_o(pb_out), .pb_oe_o(pb_oe),
		.pb_pullup_o(pb_pu), .timer_clock_o(tclk), .wake_o(wake), .prog_mode_o(), .prog_clock_o(), .prog_data_o());
	dgpio_pins u_pins (.clk_i(clk_i), .pa_out_i(pa_out), .pa_oe_i(pa_oe), .pb_out_i(pb_out), .pb_oe_i(pb_oe),
		.pb_pullup_i(pb_pu), .ext_i(ext), .en_i(en), .pa_pin_o(pa_in), .pb_pin_o(pb_in));
	always #25 clk_i = ~clk_i;
	// ****************************************************************
	// Bus access, waits, expectations and the verdict.
	// ****************************************************************
	task automatic acc(input logic w, input logic [7:0] i, input logic [7:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {i, 2'b00};
		dat_w <= {24'h0, d};
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		q = dat_r[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic settle;
		repeat (8) @(posedge clk_i);
	endtask
	function automatic logic [5:0] exp_oe(input logic [5:0] dir, input logic [5:0] lat);
		return ~dir & ~(lat & 6'h10);
	endfunction
	task automatic print_verdict;
		$display("errors %0d checks %0d", num_errors, total_checks);
		if (num_errors == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			print_verdict();
		end
	end
	initial begin
		void'($urandom(43222));
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		settle();
		for (e = 0; e < 6; e++) begin
			acc(1'b0, idx[e], 8'h00);
			`chk_eq(q, rst[e])
		end
		acc(1'b0, `DGPIO_IDX_PA_DATA, 8'h00);
		`chk_eq(q, 8'h10)
		acc(1'b1, `DGPIO_IDX_ANCFG, 8'h06);
		v = $urandom;
		ext[5:0] <= v[5:0];
		settle();
		acc(1'b0, `DGPIO_IDX_PA_DATA, 8'h00);
		`chk_eq(q, {2'b00, v[5:0]})
		`chk_eq(tclk, v[4])
		acc(1'b1, `DGPIO_IDX_ANCFG, 8'hFF);
		acc(1'b0, `DGPIO_IDX_ANCFG, 8'h00);
		`chk_eq(q, 8'h8F)
		acc(1'b1, `DGPIO_IDX_PA_DIR, v[15:8]);
		acc(1'b1, `DGPIO_IDX_PA_DATA, v[23:16]);
		acc(1'b0, `DGPIO_IDX_PA_DIR, 8'h00);
		`chk_eq(q, {2'b00, v[13:8]})
		`chk_eq(pa_oe, exp_oe(v[13:8], v[21:16]))
		`chk_eq(pa_out, v[21:16] & 6'h2F)
		acc(1'b1, `DGPIO_IDX_PB_DIR, 8'h00);
		acc(1'b1, `DGPIO_IDX_PB_DATA, v[31:24]);
		`chk_eq(pb_out, v[31:24])
		`chk_eq(pb_oe, 8'hFF)
		acc(1'b1, `DGPIO_IDX_LVPCFG, 8'h01);
		`chk_eq(pb_oe, 8'h37)
		acc(1'b1, `DGPIO_IDX_LVPCFG, 8'h00);
		acc(1'b1, `DGPIO_IDX_OPTION, 8'h7F);
		acc(1'b1, `DGPIO_IDX_PB_DIR, 8'h0F);
		`chk_eq(pb_pu, 8'h0F)
		en <= 14'h003F;
		settle();
		acc(1'b0, `DGPIO_IDX_PB_DATA, 8'h00);
		`chk_eq(q[3:0], 4'hF)
		en <= 14'h3FFF;
		acc(1'b1, `DGPIO_IDX_OPTION, 8'hFF);
		`chk_eq(pb_pu, 8'h00)
		acc(1'b1, `DGPIO_IDX_PB_DIR, 8'hFF);
		v = $urandom;
		ext[13:6] <= v[7:0];
		settle();
		acc(1'b1, `DGPIO_IDX_PB_SET, v[15:8]);
		`chk_eq(pb_out, v[7:0] | v[15:8])
		acc(1'b1, `DGPIO_IDX_PB_CLR, v[15:8]);
		`chk_eq(pb_out, v[7:0] & ~v[15:8])
		sleep <= 1'b1;
		acc(1'b0, `DGPIO_IDX_PB_DATA, 8'h00);
		acc(1'b1, `DGPIO_IDX_INTCTL, 8'h08);
		ext[7] <= ~v[1];
		settle();
		`chk_eq(wake, 1'b0)
		ext[11] <= ~v[5];
		settle();
		`chk_eq(wake, 1'b1)
		acc(1'b1, `DGPIO_IDX_INTCTL, 8'h08);
		acc(1'b0, `DGPIO_IDX_INTCTL, 8'h00);
		`chk_eq(q[0], 1'b1)
		acc(1'b0, `DGPIO_IDX_PB_DATA, 8'h00);
		acc(1'b1, `DGPIO_IDX_INTCTL, 8'h08);
		acc(1'b0, `DGPIO_IDX_INTCTL, 8'h00);
		`chk_eq(q[0], 1'b0)
		for (e = 0; e < 2; e++) begin
			acc(1'b1, `DGPIO_IDX_OPTION, e[0] ? 8'hFF : 8'hBF);
			ext[6] <= ~e[0];
			settle();
			acc(1'b1, `DGPIO_IDX_INTCTL, 8'h00);
			ext[6] <= e[0];
			settle();
			acc(1'b0, `DGPIO_IDX_INTCTL, 8'h00);
			`chk_eq(q[1], 1'b1)
		end
		print_verdict();
	end
endmodule // dgpio_port_tb
